/* shared/spp_defines.vh */
/*
 constants for the serial memory programming port: instruction codes,
 array sizes and self-timed programming delays.
 assumes a single 50 MHz system clock drives all logic.
*/
`ifndef SPP_DEFINES_VH
`define SPP_DEFINES_VH
`define SPP_OP_ENABLE 8'hAC
`define SPP_OP_SYNC 8'h53
`define SPP_OP_WR_PAGE 8'h4C
`define SPP_OP_LD_PAGE 4'h4
`define SPP_OP_RD_FLASH 4'h2
`define SPP_OP_RD_EE 8'hA0
`define SPP_OP_WR_EE 8'hC0
`define SPP_ERASE_SEL 3'h4
`define SPP_ERASED_BYTE 8'hFF
`define SPP_ERASED_WORD 16'hFFFF
`define SPP_FLASH_WORDS 17'h1_0000
`define SPP_PAGE_WORDS 17'h0_0080
`define SPP_CLK_MHZ 50
`define SPP_T_FLASH_US 4500
`define SPP_T_EEPROM_US 9000
`define SPP_T_ERASE_US 9000
`define SPP_T_FLASH_CYC 19'h3_6EE8
`define SPP_T_EEPROM_CYC 19'h6_DDD0
`define SPP_T_ERASE_CYC 19'h6_DDD0
`define SPP_STRAP_WAIT 2'h3
`endif

/* rtl/spp_top.v */
/*
 serial in-system programming port with its own flash and eeprom arrays.
 assumes the programmer follows the link timing: serial clock phases
 longer than three system clocks, and no writes while an array is busy;
 reads may poll a busy array.
*/
`timescale 1ns/1ps
`include "spp_defines.vh"
module spp_top #(
    parameter [18:0] FLASH_WAIT_CYC = `SPP_T_FLASH_CYC,
    parameter [18:0] EEPROM_WAIT_CYC = `SPP_T_EEPROM_CYC,
    parameter [18:0] ERASE_WAIT_CYC = `SPP_T_ERASE_CYC
) (
    // system
    input wire CLK_SYS_I,
    input wire RESETN_I,
    // device pins
    input wire DEV_RESETN_I,
    input wire PROGRAM_ENTRY_PIN_N_I,
    // serial link
    input wire SCK_I,
    input wire SERIAL_PROG_DATA_IN_I,
    output wire SERIAL_PROG_DATA_OUT_O,
    output wire SERIAL_PROG_DATA_OUT_OE_O,
    // status
    output wire PROG_ACTIVE_O,
    output wire PROG_ENABLED_O,
    output wire NVM_BUSY_O
);
    localparam MODE_FLASH = 2'd0;
    localparam MODE_EE = 2'd1;
    localparam MODE_ERASE = 2'd2;

    reg [15:0] flash_mem [0:65535];
    reg [7:0] ee_mem [0:4095];
    reg [15:0] page_buf [0:127];

    reg sck_s1_reg, sck_s2_reg, sck_s3_reg;
    reg mosi_s1_reg, mosi_s2_reg;
    reg rst_s1_reg, rst_s2_reg;
    reg pen_s1_reg, pen_s2_reg;
    reg [1:0] strap_cnt_reg;
    reg strap_done_reg, pen_mode_reg, prog_reg;

    reg [2:0] bit_cnt_reg;
    reg [1:0] bidx_reg;
    reg [7:0] sh_in_reg, out_reg;
    reg [7:0] b0_reg, b1_reg, b2_reg, last_reg;

    reg [7:0] fifo0_reg, fifo1_reg;
    reg wr_ptr_reg, rd_ptr_reg;
    reg [1:0] fcnt_reg;

    reg [1:0] eidx_reg;
    reg [7:0] e0_reg, e1_reg, e2_reg;
    reg en_reg;
    reg busy_reg;
    reg [1:0] mode_reg;
    reg [18:0] timer_reg;
    reg [16:0] sweep_reg;
    reg [8:0] page_reg;
    reg [11:0] ee_addr_reg;

    wire sck_rise = sck_s2_reg & ~sck_s3_reg;
    wire sck_fall = ~sck_s2_reg & sck_s3_reg;
    wire [7:0] rx_byte = {sh_in_reg[6:0], mosi_s2_reg};
    wire byte_done = prog_reg & sck_rise & (bit_cnt_reg == 3'd7);
    wire fifo_ready = (fcnt_reg != 2'd2);
    wire fifo_valid = (fcnt_reg != 2'd0);
    wire [7:0] fifo_head = rd_ptr_reg ? fifo1_reg : fifo0_reg;
    wire rd_op = (e0_reg[7:4] == `SPP_OP_RD_FLASH && e0_reg[2:0] == 3'd0) ||
                 (e0_reg == `SPP_OP_RD_EE);
    // the final byte of any instruction but a read waits for the array
    wire exec_stall = busy_reg & (eidx_reg == 2'd3) & ~rd_op;
    wire pop = fifo_valid & ~exec_stall;
    wire push = byte_done & fifo_ready;
    wire overrun = byte_done & ~fifo_ready;
    wire [16:0] sweep_lim = (mode_reg == MODE_ERASE) ? `SPP_FLASH_WORDS :
                            (mode_reg == MODE_FLASH) ? `SPP_PAGE_WORDS :
                            17'h0_0000;
    wire sweep_act = busy_reg & (sweep_reg < sweep_lim);
    wire [15:0] sweep_addr = (mode_reg == MODE_ERASE) ? sweep_reg[15:0] :
                             {page_reg, sweep_reg[6:0]};

    // read answer, ff while the addressed location is being programmed
    function [7:0] spp_read;
        input [7:0] op;
        input [7:0] ah;
        input [7:0] al;
        input bsy;
        input [1:0] md;
        input [8:0] pg;
        input [11:0] ea;
        reg [15:0] w;
        begin
            w = flash_mem[{ah, al}];
            spp_read = `SPP_ERASED_BYTE;
            if (op[7:4] == `SPP_OP_RD_FLASH && op[2:0] == 3'd0) begin
                if (!(bsy && md == MODE_FLASH && pg == {ah, al[7]}))
                    spp_read = op[3] ? w[15:8] : w[7:0];
            end else if (op == `SPP_OP_RD_EE) begin
                if (!(bsy && md == MODE_EE && ea == {ah[3:0], al}))
                    spp_read = ee_mem[{ah[3:0], al}];
            end
        end
    endfunction

    // pins cross into the system clock domain
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_s3_reg <= 1'b0;
            mosi_s1_reg <= 1'b0;
            mosi_s2_reg <= 1'b0;
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= 1'b1;
            pen_s1_reg <= 1'b1;
            pen_s2_reg <= 1'b1;
        end else begin
            sck_s1_reg <= SCK_I;
            sck_s2_reg <= sck_s1_reg;
            sck_s3_reg <= sck_s2_reg;
            mosi_s1_reg <= SERIAL_PROG_DATA_IN_I;
            mosi_s2_reg <= mosi_s1_reg;
            rst_s1_reg <= DEV_RESETN_I;
            rst_s2_reg <= rst_s1_reg;
            pen_s1_reg <= PROGRAM_ENTRY_PIN_N_I;
            pen_s2_reg <= pen_s1_reg;
        end
    end

    // entry: pin strap caught once after power-on, reset pin any time
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            strap_cnt_reg <= 2'd0;
            strap_done_reg <= 1'b0;
            pen_mode_reg <= 1'b0;
            prog_reg <= 1'b0;
        end else begin
            if (!strap_done_reg) begin
                strap_cnt_reg <= strap_cnt_reg + 2'd1;
                if (strap_cnt_reg == `SPP_STRAP_WAIT) begin
                    strap_done_reg <= 1'b1;
                    pen_mode_reg <= ~pen_s2_reg;
                end
            end
            prog_reg <= strap_done_reg & (~rst_s2_reg | pen_mode_reg);
        end
    end

    // serial shifter: in on rise, out on fall
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            bit_cnt_reg <= 3'd0;
            bidx_reg <= 2'd0;
            sh_in_reg <= 8'h00;
            out_reg <= 8'h00;
            b0_reg <= 8'h00;
            b1_reg <= 8'h00;
            b2_reg <= 8'h00;
            last_reg <= 8'h00;
        end else if (!prog_reg) begin
            bit_cnt_reg <= 3'd0;
            bidx_reg <= 2'd0;
            sh_in_reg <= 8'h00;
            out_reg <= 8'h00;
            last_reg <= 8'h00;
        end else if (sck_rise) begin
            sh_in_reg <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'd1;
            if (bit_cnt_reg == 3'd7) begin
                bidx_reg <= bidx_reg + 2'd1;
                last_reg <= rx_byte;
                if (bidx_reg == 2'd0)
                    b0_reg <= rx_byte;
                if (bidx_reg == 2'd1)
                    b1_reg <= rx_byte;
                if (bidx_reg == 2'd2)
                    b2_reg <= rx_byte;
            end
        end else if (sck_fall) begin
            if (bit_cnt_reg == 3'd0) begin
                // read data in the fourth byte
                if (bidx_reg == 2'd3 && en_reg)
                    out_reg <= spp_read(b0_reg, b1_reg, b2_reg, busy_reg,
                                        mode_reg, page_reg, ee_addr_reg);
                else
                    out_reg <= last_reg;
            end else begin
                out_reg <= {out_reg[6:0], 1'b0};
            end
        end
    end

    // two-entry byte buffer; a write arriving while busy stalls it
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            fifo0_reg <= 8'h00;
            fifo1_reg <= 8'h00;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            fcnt_reg <= 2'd0;
        end else if (!prog_reg) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            fcnt_reg <= 2'd0;
        end else begin
            if (push) begin
                if (wr_ptr_reg)
                    fifo1_reg <= rx_byte;
                else
                    fifo0_reg <= rx_byte;
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            if (push && !pop)
                fcnt_reg <= fcnt_reg + 2'd1;
            else if (pop && !push)
                fcnt_reg <= fcnt_reg - 2'd1;
        end
    end

    // instruction executor and self-timer
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            eidx_reg <= 2'd0;
            e0_reg <= 8'h00;
            e1_reg <= 8'h00;
            e2_reg <= 8'h00;
            en_reg <= 1'b0;
            busy_reg <= 1'b0;
            mode_reg <= MODE_FLASH;
            timer_reg <= 19'd0;
            sweep_reg <= 17'd0;
            page_reg <= 9'd0;
            ee_addr_reg <= 12'd0;
        end else begin
            if (busy_reg) begin
                if (sweep_act)
                    sweep_reg <= sweep_reg + 17'd1;
                if (timer_reg != 19'd0)
                    timer_reg <= timer_reg - 19'd1;
                else if (!sweep_act)
                    busy_reg <= 1'b0;
            end
            if (!prog_reg) begin
                eidx_reg <= 2'd0;
                en_reg <= 1'b0;
            end else if (overrun) begin
                en_reg <= 1'b0;
            end else if (pop) begin
                eidx_reg <= eidx_reg + 2'd1;
                if (eidx_reg == 2'd0)
                    e0_reg <= fifo_head;
                if (eidx_reg == 2'd1)
                    e1_reg <= fifo_head;
                if (eidx_reg == 2'd2)
                    e2_reg <= fifo_head;
                if (eidx_reg == 2'd3) begin
                    if (e0_reg == `SPP_OP_ENABLE && e1_reg == `SPP_OP_SYNC)
                        en_reg <= 1'b1;
                    else if (en_reg && e0_reg == `SPP_OP_ENABLE &&
                             e1_reg[7:5] == `SPP_ERASE_SEL) begin
                        busy_reg <= 1'b1;
                        mode_reg <= MODE_ERASE;
                        sweep_reg <= 17'd0;
                        timer_reg <= ERASE_WAIT_CYC;
                    end else if (en_reg && e0_reg == `SPP_OP_WR_PAGE) begin
                        busy_reg <= 1'b1;
                        mode_reg <= MODE_FLASH;
                        sweep_reg <= 17'd0;
                        page_reg <= {e1_reg, e2_reg[7]};
                        timer_reg <= FLASH_WAIT_CYC;
                    end else if (en_reg && e0_reg == `SPP_OP_WR_EE) begin
                        busy_reg <= 1'b1;
                        mode_reg <= MODE_EE;
                        sweep_reg <= 17'd0;
                        ee_addr_reg <= {e1_reg[3:0], e2_reg};
                        timer_reg <= EEPROM_WAIT_CYC;
                    end
                end
            end
        end
    end

    // array write ports; arrays carry no reset, only chip erase clears flash and eeprom
    always @(posedge CLK_SYS_I) begin
        if (sweep_act) begin
            if (mode_reg == MODE_ERASE) begin
                flash_mem[sweep_addr] <= `SPP_ERASED_WORD;
                ee_mem[sweep_reg[11:0]] <= `SPP_ERASED_BYTE;
            end else begin
                flash_mem[sweep_addr] <= page_buf[sweep_reg[6:0]];
            end
        end
        if (prog_reg && pop && !overrun && en_reg && eidx_reg == 2'd3) begin
            // page load by low address bits
            if (e0_reg[7:4] == `SPP_OP_LD_PAGE && e0_reg[2:0] == 3'd0 &&
                e0_reg != `SPP_OP_WR_PAGE) begin
                if (e0_reg[3])
                    page_buf[e2_reg[6:0]][15:8] <= fifo_head;
                else
                    page_buf[e2_reg[6:0]][7:0] <= fifo_head;
            end
            if (e0_reg == `SPP_OP_WR_EE)
                ee_mem[{e1_reg[3:0], e2_reg}] <= fifo_head;
        end
    end

    assign SERIAL_PROG_DATA_OUT_O = out_reg[7];
    assign SERIAL_PROG_DATA_OUT_OE_O = prog_reg;
    assign PROG_ACTIVE_O = prog_reg;
    assign PROG_ENABLED_O = en_reg;
    assign NVM_BUSY_O = busy_reg;
endmodule

/* verif/spp_top_properties.sv */
/*
 checker for the serial programming port, bound to spp_top below.
 assumes the entry strap, once low, stays low until power-on reset;
 while it is high the device reset pin alone decides the state.
*/
`timescale 1ns/1ps
module spp_top_properties (
    // system
    input wire CLK_SYS_I,
    input wire RESETN_I,
    // device pins and link
    input wire DEV_RESETN_I,
    input wire PROGRAM_ENTRY_PIN_N_I,
    input wire SCK_I,
    input wire SERIAL_PROG_DATA_IN_I,
    // watched outputs
    input wire SERIAL_PROG_DATA_OUT_O,
    input wire SERIAL_PROG_DATA_OUT_OE_O,
    input wire PROG_ACTIVE_O,
    input wire PROG_ENABLED_O,
    input wire NVM_BUSY_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESETN_I);
    a_enable_needs_active: assert property (
        PROG_ENABLED_O |-> PROG_ACTIVE_O) else $error("enable while idle");
    a_busy_needs_enable: assert property (
        $rose(NVM_BUSY_O) |-> $past(PROG_ENABLED_O))
        else $error("array work started without enable");
    a_enable_after_rise: assert property (
        $rose(PROG_ENABLED_O) |-> $past(SCK_I, 4))
        else $error("enable not tied to a clock rise");
    a_out_after_fall: assert property (
        $changed(SERIAL_PROG_DATA_OUT_O) && $past(PROG_ACTIVE_O)
        |-> !$past(SCK_I, 2)) else $error("output moved in high phase");
    a_oe_follows_state: assert property (
        PROG_ACTIVE_O == SERIAL_PROG_DATA_OUT_OE_O)
        else $error("output enable disagrees with state");
    a_exit_drops_enable: assert property (
        $fell(PROG_ACTIVE_O) |-> ##[0:1] !PROG_ENABLED_O)
        else $error("enable survived exit");
    a_release_ends_prog: assert property (
        (PROGRAM_ENTRY_PIN_N_I && DEV_RESETN_I) [*4] |-> ##[0:2]
        !PROG_ACTIVE_O) else $error("reset pin release ignored");
    a_busy_min_len: assert property (
        $rose(NVM_BUSY_O) |-> NVM_BUSY_O [*8])
        else $error("busy too short");
endmodule
bind spp_top spp_top_properties u_props (
    .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I),
    .DEV_RESETN_I(DEV_RESETN_I),
    .PROGRAM_ENTRY_PIN_N_I(PROGRAM_ENTRY_PIN_N_I),
    .SCK_I(SCK_I), .SERIAL_PROG_DATA_IN_I(SERIAL_PROG_DATA_IN_I),
    .SERIAL_PROG_DATA_OUT_O(SERIAL_PROG_DATA_OUT_O),
    .SERIAL_PROG_DATA_OUT_OE_O(SERIAL_PROG_DATA_OUT_OE_O),
    .PROG_ACTIVE_O(PROG_ACTIVE_O), .PROG_ENABLED_O(PROG_ENABLED_O),
    .NVM_BUSY_O(NVM_BUSY_O));

/* verif/spp_prog_model.sv */
/*
 behavioural in-system programmer: shifts 4-byte instructions.
 assumes the caller waits for busy to clear between array writes.
*/
`timescale 1ns/1ps
module spp_prog_model #(
    parameter integer HALF_NS = 80,
    parameter integer ENTRY_WAIT_NS = 2000
) (
    // link
    output reg sck_o,
    output reg mosi_o,
    input wire miso_i
);
    initial begin
        sck_o = 1'b0;
        mosi_o = 1'b0;
    end
    task settle;
        #(ENTRY_WAIT_NS);
    endtask
    task xfer(input [31:0] tx, output [31:0] rx);
        integer i;
        begin
            #7;
            for (i = 31; i >= 0; i = i - 1) begin
                mosi_o = tx[i];
                #(HALF_NS);
                sck_o = 1'b1;
                #(HALF_NS);
                // sample late: output settles well after the fall
                rx[i] = miso_i;
                sck_o = 1'b0;
            end
            #(HALF_NS);
            mosi_o = ~mosi_o;
            #(4 * HALF_NS);
        end
    endtask
endmodule

/* verif/tb.sv */
/*
 testbench for spp_top: enable, erase, eeprom, page and overrun cases.
 assumes shortened wait parameters; the erase sweep still runs in full.
*/
`timescale 1ns/1ps
module tb;
    reg clk_sys;
    reg resetn;
    reg dev_resetn;
    reg entry_n;
    wire sck, mosi, miso, miso_oe, active, enabled, busy;
    integer n_errors;
    integer n_tests;
    reg [31:0] rx;
    integer k;
    always #10 clk_sys = ~clk_sys;
    spp_top #(.FLASH_WAIT_CYC(19'h0_0190), .EEPROM_WAIT_CYC(19'h0_07D0),
        .ERASE_WAIT_CYC(19'h0_00C8)) u_spp_top (
        .CLK_SYS_I(clk_sys), .RESETN_I(resetn), .DEV_RESETN_I(dev_resetn),
        .PROGRAM_ENTRY_PIN_N_I(entry_n), .SCK_I(sck),
        .SERIAL_PROG_DATA_IN_I(mosi), .SERIAL_PROG_DATA_OUT_O(miso),
        .SERIAL_PROG_DATA_OUT_OE_O(miso_oe), .PROG_ACTIVE_O(active),
        .PROG_ENABLED_O(enabled), .NVM_BUSY_O(busy));
    spp_prog_model u_spp_prog_model (.sck_o(sck), .mosi_o(mosi),
        .miso_i(miso));
    task check(input [8*12-1:0] name, input [7:0] seen, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected %0s: expected %h seen %h", name, exp,
                    seen);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", n_tests, n_errors);
            if (n_errors == 0 && n_tests > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task idle(input integer n);
        begin
            repeat (n) @(posedge clk_sys);
            #1;
        end
    endtask
    task wait_idle(input integer lim);
        begin
            k = 0;
            while (busy !== 1'b0 && k < lim) begin
                @(posedge clk_sys);
                k = k + 1;
            end
            if (busy !== 1'b0) begin
                check("busy timeout", busy, 8'h00);
                give_verdict;
            end
        end
    endtask
    task send(input [31:0] tx);
        u_spp_prog_model.xfer(tx, rx);
    endtask
    task t_refused;
        begin
            send(32'hAC80_0000);
            idle(8);
            check("busy", busy, 8'h00);
            check("enabled", enabled, 8'h00);
        end
    endtask
    task t_enable;
        begin
            send(32'hAC53_0000);
            check("echo", rx[15:8], 8'h53);
            idle(4);
            check("enabled", enabled, 8'h01);
        end
    endtask
    task t_erase;
        begin
            send(32'hAC80_0000);
            idle(4);
            check("busy", busy, 8'h01);
            wait_idle(80000);
            send(32'h2000_0100);
            check("flash lo", rx[7:0], 8'hFF);
            send(32'h2800_0100);
            check("flash hi", rx[7:0], 8'hFF);
            send(32'hA000_0200);
            check("eeprom", rx[7:0], 8'hFF);
        end
    endtask
    task t_eeprom;
        reg [7:0] v;
        begin
            v = 8'h5A;
            repeat (2) begin
                send({24'hC0_0123, v});
                wait_idle(3000);
                send(32'hA001_2300);
                check("ee read", rx[7:0], v);
                v = ~v;
            end
        end
    endtask
    task t_page;
        begin
            send(32'h4000_0511);
            send(32'h4800_0522);
            send(32'h4C01_8000);
            send(32'h2001_8500);
            check("page busy", rx[7:0], 8'hFF);
            wait_idle(1000);
            send(32'h2001_8500);
            check("page lo", rx[7:0], 8'h11);
            send(32'h2801_8500);
            check("page hi", rx[7:0], 8'h22);
        end
    endtask
    task t_overrun;
        begin
            send(32'hC000_1077);
            // write while busy: its last byte stalls, the next fills the buffer, the three after overrun
            send(32'hC000_1088);
            send(32'hA000_1000);
            idle(2);
            check("enabled", enabled, 8'h00);
            wait_idle(3000);
            @(posedge clk_sys) dev_resetn <= 1'b1;
            idle(8);
            check("active", active, 8'h00);
            check("miso oe", miso_oe, 8'h00);
            @(posedge clk_sys) dev_resetn <= 1'b0;
            idle(8);
            check("active", active, 8'h01);
            t_enable;
            send(32'hA000_1000);
            check("ee read", rx[7:0], 8'h77);
        end
    endtask
    task t_strap;
        begin
            @(posedge clk_sys);
            resetn <= 1'b0;
            entry_n <= 1'b0;
            dev_resetn <= 1'b1;
            repeat (20) @(posedge clk_sys);
            resetn <= 1'b1;
            idle(8);
            check("active", active, 8'h01);
            check("enabled", enabled, 8'h00);
            @(posedge clk_sys) dev_resetn <= 1'b0;
            idle(8);
            @(posedge clk_sys) dev_resetn <= 1'b1;
            idle(8);
            check("active", active, 8'h01);
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        resetn = 1'b0;
        dev_resetn = 1'b0;
        entry_n = 1'b1;
        n_errors = 0;
        n_tests = 0;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        idle(8);
        check("active", active, 8'h01);
        check("miso oe", miso_oe, 8'h01);
        u_spp_prog_model.settle;
        t_refused;
        t_enable;
        t_erase;
        t_eeprom;
        t_page;
        t_overrun;
        t_strap;
        give_verdict;
    end
endmodule
